// File: system_watchdog_timer.v
// The APB register port and the register addresses were decided locally.
`timescale 1ns/1ps
`include "wdt_consts.vh"

module system_watchdog_timer #(
  parameter CNT_W = 24
) (
  // apb slave
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // outputs to the system
  output reg         irq_q,
  output reg         sys_reset_q
);

  reg  [3:0]       ctrl_q;
  reg  [1:0]       status_q;
  reg  [1:0]       mask_q;
  reg  [CNT_W-1:0] count_q;
  reg  [3:0]       rst_cnt_q;
  reg              restart_q;
  reg              tmo_hit;
  reg  [1:0]       status_d;
  reg  [31:0]      rdata_d;
  reg              map_ok;
  wire [1:0]       timeout_select;
  wire             irq_en;
  wire             rst_en;
  wire             wr;
  wire             rd;
  wire             win_expired;
  wire             win_running;

  // timeout exponent for a select code
  function [4:0] sel_exp;
    input [1:0] sel;
    begin
      case (sel)
        2'b00:   sel_exp = `WDT_EXP_SEL0;
        2'b01:   sel_exp = `WDT_EXP_SEL1;
        2'b10:   sel_exp = `WDT_EXP_SEL2;
        default: sel_exp = `WDT_EXP_SEL3;
      endcase
    end
  endfunction

  assign timeout_select = ctrl_q[`WDT_CTRL_SEL_HI:`WDT_CTRL_SEL_LO];
  assign irq_en         = ctrl_q[`WDT_CTRL_IE_BIT];
  assign rst_en         = ctrl_q[`WDT_CTRL_RE_BIT];
  assign wr             = psel & penable & pwrite;
  assign rd             = psel & ~penable & ~pwrite;

  ////////////////////////////////////////////////////////////////////////////
  // address decode; every access completes in its first access cycle
  always @* begin
    map_ok = 1'b1;
    case (paddr)
      `WDT_OFF_CTRL:    rdata_d = {28'h0000000, ctrl_q};
      `WDT_OFF_RESTART: rdata_d = 32'h00000000;
      `WDT_OFF_STATUS:  rdata_d = {30'h00000000, status_q};
      `WDT_OFF_MASK:    rdata_d = {30'h00000000, mask_q};
      `WDT_OFF_COUNT:   rdata_d = {{(32-CNT_W){1'b0}}, count_q};
      default: begin
        rdata_d = 32'h00000000;
        map_ok  = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb response regs; ready is raised in setup so access is one cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~map_ok;
      if (rd)
        prdata <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control and mask writes; restart needs a key so stray writes miss
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q    <= `WDT_CTRL_RST;
      mask_q    <= `WDT_MASK_RST;
      restart_q <= 1'b0;
    end else begin
      restart_q <= wr && (paddr == `WDT_OFF_RESTART)
                   && (pwdata == `WDT_RESTART_KEY);
      if (wr && paddr == `WDT_OFF_CTRL)
        ctrl_q <= pwdata[3:0];
      if (wr && paddr == `WDT_OFF_MASK)
        mask_q <= pwdata[1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // timeout hit when the count reaches 2^n - 1 for the selected n
  always @* begin
    tmo_hit = (count_q[CNT_W-1:0] ==
               ((({{(CNT_W-1){1'b0}}, 1'b1}) << sel_exp(timeout_select))
                - {{(CNT_W-1){1'b0}}, 1'b1}));
    if (sel_exp(timeout_select) == 5'd24)
      tmo_hit = &count_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // free-running count; wraps at the period so timeouts repeat
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      count_q <= {CNT_W{1'b0}};
    else if (restart_q || tmo_hit)
      count_q <= {CNT_W{1'b0}};
    else
      count_q <= count_q + {{(CNT_W-1){1'b0}}, 1'b1};
  end

  wdt_window u_window (
    .pclk      (pclk),
    .presetn   (presetn),
    .start     (tmo_hit),
    .clear     (restart_q),
    .expired_q (win_expired),
    .running_q (win_running)
  );

  ////////////////////////////////////////////////////////////////////////////
  // sticky status; a set in the same cycle as a clear wins
  always @* begin
    status_d = status_q;
    if (wr && paddr == `WDT_OFF_STATUS)
      status_d = status_q & ~pwdata[1:0];
    if (tmo_hit && irq_en)
      status_d[`WDT_ST_TIMEOUT] = 1'b1;
    if (win_expired)
      status_d[`WDT_ST_RESET] = 1'b1;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q <= 2'b00;
      irq_q    <= 1'b0;
    end else begin
      status_q <= status_d;
      irq_q    <= |(status_d & mask_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // system reset pulse when the window runs out without a restart
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_cnt_q   <= 4'h0;
      sys_reset_q <= 1'b0;
    end else if (win_expired && rst_en) begin
      rst_cnt_q   <= `WDT_RST_PULSE;
      sys_reset_q <= 1'b1;
    end else if (rst_cnt_q != 4'h0) begin
      rst_cnt_q   <= rst_cnt_q - 4'h1;
      sys_reset_q <= (rst_cnt_q != 4'h1);
    end else begin
      sys_reset_q <= 1'b0;
    end
  end

endmodule // system_watchdog_timer

// File: testbench.sv
`timescale 1ns/1ps
`include "wdt_consts.vh"

module testbench;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] x = 32'h0000EBA9;
  logic [31:0] prdata, rd, v;
  logic        pready, pslverr, irq_q, sys_reset_q, er;
  int          n_errors = 0;
  int          n_checks = 0;
  int          n;

  system_watchdog_timer DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq_q(irq_q),
    .sys_reset_q(sys_reset_q));

  // 200 MHz clock
  initial begin
    forever #2.5 pclk = ~pclk;
  end

  function automatic logic [31:0] rnd();
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // one apb transfer; request held until pready is seen at a rising edge,
  // data and error taken at that same edge, then released
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    for (k = 1; k < 16 && pready !== 1'b1; k++)
      @(posedge pclk);
    if (pready !== 1'b1) begin
      n_errors++;
      report_and_stop();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // bounded wait for irq (s=0) or system reset (s=1); n counts cycles
  task automatic wait_out(input logic s, input int lim);
    for (n = 0; n < lim && (s ? sys_reset_q : irq_q) !== 1'b1; n++)
      @(negedge pclk);
    if (n == lim) begin
      n_errors++;
      report_and_stop();
    end
  endtask

  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `WDT_OFF_CTRL, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 12'h014, 32'h0);
    chk({31'h0, er}, 32'h1);
    $display("test reset and unmapped done");
    // every select code with random enable bits
    for (int i = 0; i < 4; i++) begin
      v = (rnd() & 32'h0000000C) | i;
      apb(1'b1, `WDT_OFF_CTRL, v);
      apb(1'b0, `WDT_OFF_CTRL, 32'h0);
      chk(rd, v);
    end
    $display("test select codes done");
    apb(1'b1, `WDT_OFF_MASK, 32'h1);
    apb(1'b1, `WDT_OFF_CTRL, 32'h0000000C);
    apb(1'b1, `WDT_OFF_RESTART, `WDT_RESTART_KEY);
    // count read a random number of cycles after the restart
    v = rnd() & 32'h000003FF;
    repeat (v) @(posedge pclk);
    apb(1'b0, `WDT_OFF_COUNT, 32'h0);
    chk(rd, v);
    repeat (20000) @(posedge pclk);
    apb(1'b1, `WDT_OFF_RESTART, `WDT_RESTART_KEY);
    repeat (10000) @(posedge pclk);
    // a wrong key must not restart
    apb(1'b1, `WDT_OFF_RESTART, rnd() | 32'h00010000);
    wait_out(1'b0, 40000);
    chk(32'(n >= 22755 && n <= 22775), 32'h1);
    wait_out(1'b1, 1000);
    chk(32'(n >= 505 && n <= 520), 32'h1);
    apb(1'b0, `WDT_OFF_STATUS, 32'h0);
    chk(rd, 32'h3);
    $display("test timeout and reset done");
    apb(1'b1, `WDT_OFF_MASK, 32'h0);
    // irq_q takes the new mask one edge after the write edge
    repeat (2) @(negedge pclk);
    chk({31'h0, irq_q}, 32'h0);
    apb(1'b1, `WDT_OFF_STATUS, 32'h3);
    apb(1'b0, `WDT_OFF_STATUS, 32'h0);
    chk(rd, 32'h0);
    $display("test mask and clear done");
    report_and_stop();
  end
endmodule // testbench

// File: wdt_checker_props.sv
`timescale 1ns/1ps
`include "wdt_consts.vh"

// watches the apb handshake and the reset pulse at the top ports
module wdt_checker (
  // apb side
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // system side
  input wire logic        sys_reset_q
);
  // cycles since the last keyed restart; saturates at 65536, twice the shortest timeout
  logic [16:0] since_q;
  wire         rs = psel && penable && pwrite && pready &&
                    paddr == `WDT_OFF_RESTART && pwdata == `WDT_RESTART_KEY;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      since_q <= 17'h00000;
    else if (rs)
      since_q <= 17'h00000;
    else if (!since_q[16])
      since_q <= since_q + 17'h00001;
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // reset output is high for exactly eight cycles
  sequence pulse_8;
    sys_reset_q [*8] ##1 !sys_reset_q;
  endsequence

  AST_READY_FIRST: assert property (psel && !penable |=> pready)
    else $error("pready missing in access cycle");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  AST_ERR_UNMAPPED: assert property (psel && !penable &&
    paddr > `WDT_OFF_COUNT |=> pslverr)
    else $error("unmapped access not refused");
  AST_ERR_MAPPED: assert property (psel && !penable &&
    paddr == `WDT_OFF_CTRL |=> !pslverr)
    else $error("mapped access refused");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  AST_RST_PULSE: assert property ($rose(sys_reset_q) |-> pulse_8)
    else $error("reset pulse length wrong");
  AST_RST_LATE: assert property ($rose(sys_reset_q) |->
    since_q >= 17'h08200)
    else $error("system reset before timeout plus window");
  AST_RESTART_QUIET: assert property (rs |=> (!$rose(sys_reset_q)) [*8])
    else $error("system reset right after a restart");
endmodule // wdt_checker

////////////////////////////////////////////////////////////////////////////
bind system_watchdog_timer wdt_checker u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .sys_reset_q(sys_reset_q));

// File: wdt_consts.vh
`ifndef WDT_CONSTS_VH
`define WDT_CONSTS_VH

// register byte offsets
`define WDT_OFF_CTRL     12'h000
`define WDT_OFF_RESTART  12'h004
`define WDT_OFF_STATUS   12'h008
`define WDT_OFF_MASK     12'h00C
`define WDT_OFF_COUNT    12'h010

// control field positions
`define WDT_CTRL_SEL_LO  0
`define WDT_CTRL_SEL_HI  1
`define WDT_CTRL_IE_BIT  2
`define WDT_CTRL_RE_BIT  3

// status / mask bit positions
`define WDT_ST_TIMEOUT   0
`define WDT_ST_RESET     1

// reset values
`define WDT_CTRL_RST     4'h0
`define WDT_MASK_RST     2'h0

// restart key written to the restart register
`define WDT_RESTART_KEY  32'h0000A5A5

// timeout exponents for select codes 00..11
`define WDT_EXP_SEL0     5'd15
`define WDT_EXP_SEL1     5'd18
`define WDT_EXP_SEL2     5'd21
`define WDT_EXP_SEL3     5'd24

// reset window length in system clock cycles
`define WDT_RESET_WINDOW 10'd512

// cycles the system reset output is held
`define WDT_RST_PULSE    4'd8

`endif

// File: wdt_window.v
`timescale 1ns/1ps
`include "wdt_consts.vh"

module wdt_window (
  // clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // control
  input  wire        start,
  input  wire        clear,
  // status
  output reg         expired_q,
  output reg         running_q
);

  reg  [9:0] cnt_q;

  ////////////////////////////////////////////////////////////////////////////
  // counts the reset window after each timeout; clear beats start
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q     <= 10'h000;
      running_q <= 1'b0;
      expired_q <= 1'b0;
    end else begin
      expired_q <= 1'b0;
      if (clear) begin
        running_q <= 1'b0;
        cnt_q     <= 10'h000;
      end else if (start && !running_q) begin
        running_q <= 1'b1;
        cnt_q     <= 10'h001;
      end else if (running_q) begin
        if (cnt_q == `WDT_RESET_WINDOW - 10'd1) begin
          running_q <= 1'b0;
          expired_q <= 1'b1;
          cnt_q     <= 10'h000;
        end else begin
          cnt_q <= cnt_q + 10'd1;
        end
      end
    end
  end

endmodule // wdt_window
